// [common/qps_pkg.sv]
package qps_pkg;
    // Timing
    localparam int CLK_NS = 40;
    localparam int SLOT_NS = 2000000;
    localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int BURN_NS = 100000000;
    localparam int BURN_CYC = (BURN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 23;

    // Register offsets
    localparam logic [7:0] RAIL_CTL_OFS = 8'h0C;
    localparam logic [7:0] ADDR_CTL_OFS = 8'h0D;
    localparam logic [7:0] SYS_CTL_OFS = 8'h0E;
    localparam logic [7:0] UNLOCK_OFS = 8'h11;
    localparam logic [7:0] STATUS_OFS = 8'h12;
    localparam logic [7:0] PAGE_INFO_OFS = 8'h13;
    localparam logic [7:0] SLOT_SEL_OFS = 8'h14;

    // Field positions
    localparam int RAIL1_EN_BIT = 7;
    localparam int SEQ_OFF_BIT = 5;
    localparam int ADDR_LSB = 0;
    localparam int BURN_BIT = 5;
    localparam int GPIO_MODE_LSB = 6;
    localparam logic [1:0] GPIO_ADDR_MODE = 2'h0;
    localparam logic [1:0] ADDR_FIXED = 2'h3;

    // Stored defaults, restored on undervoltage
    localparam logic [7:0] RAIL_CTL_RST = 8'hF0;
    localparam logic [7:0] ADDR_CTL_RST = 8'h28;
    localparam logic [7:0] SYS_CTL_RST = 8'h40;
    localparam logic [7:0] SLOT_SEL_RST = 8'hE4;
    localparam logic [7:0] UNLOCK_RST = 8'h00;

    // Arbitrary values, not taken from any real part
    localparam logic [7:0] UNLOCK_CODE = 8'h5A;
    localparam logic [3:0] VENDOR_ID = 4'h3;

    localparam logic [2:0] OFF_SLOT_START = 3'h4;
    localparam logic [2:0] ON_SLOT_LAST = 3'h4;

    typedef enum logic [2:0] {
        ST_NO_SUPPLY = 3'b000,
        ST_POWER_OFF = 3'b001,
        ST_ON_SEQ = 3'b010,
        ST_POWER_ON = 3'b011,
        ST_OFF_SEQ = 3'b100,
        ST_THERMAL_HOLD = 3'b101
    } qps_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } qps_req_t;
endpackage

// [rtl/qps_sequencer.sv]
`timescale 1ns/1ps
// How it works
// - Burn trigger writable only while unlock register holds the unlock code.
// - Status bits 7..4 show live power-good of rails 1 to 4.
// - Status bit 3 follows the die hot warning detector.
// - Status bit 2 is high while held in thermal shutdown.
// - Page info bit 3 is checksum error; high until a burn has happened.
// - Page info bits 2..0 give the active stored page index.
// - In address pin mode the pin band overrides register address bits.
// - Four pin bands map to addresses 1101000 through 1101011 while address register bits 4..2 hold 010.
// - Address register bits 4..0 give A5..A1; A7 and A6 fixed at one.
// - Default slave address is 1101000.
// - Address register writes change the response address on the next clock.
// - Enable low keeps rails off; registers stay usable above undervoltage.
// - Power-off: rails off, enable high starts the power-on sequence.
// - Rails turn on in slot order; enable low aborts to power-off.
// - Power-on: enabled rails run and power good is high.
// - Enable high starts sequence; each rail only if its enable bit set.
// - After thermal shutdown, cooling with enable high restarts the power-on sequence; with enable low it goes to power-off.
// - Four time slots; each rail starts in its selected slot.
// - Enable low while powered starts the power-off sequence.
// - Power good drops before rails; sequenced mode turns off in reverse order.
// - Enable is ignored during the whole power-off sequence.
// - With sequenced shutdown clear, all rails turn off together.
// - Burn end clears the trigger and increments the page index.
// - Undervoltage restores register defaults; thermal shutdown keeps them.
module qps_sequencer #(
    parameter int SLOT_CYCLES = qps_pkg::SLOT_CYC,
    parameter int BURN_CYCLES = qps_pkg::BURN_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic supply_undervoltage_lockout,
    input wire logic enable_sync_input,
    input wire logic die_over_temp,
    input wire logic die_hot_warning,
    input wire logic [3:0] rail_good,
    input wire logic [1:0] add_band,
    input wire logic burn_crc_error,
    input wire qps_pkg::qps_req_t reg_req,
    output logic [3:0] rail_enable,
    output logic power_good_output,
    output logic thermal_shutdown_flag,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic wr_refused,
    output logic [6:0] slave_addr
);
    import qps_pkg::*;

    qps_state_t state;
    qps_state_t next_state;
    logic [2:0] on_slot;
    logic [2:0] off_slot;
    logic [CNT_W-1:0] slot_cnt;
    logic [CNT_W-1:0] burn_cnt;
    logic [7:0] rail_ctl;
    logic [7:0] addr_ctl;
    logic [7:0] sys_ctl;
    logic [7:0] slot_sel;
    logic [7:0] unlock;
    logic [2:0] active_page_index;
    logic crc_flag;

    // Two-bit slot selection of one rail
    function automatic logic [2:0] slot_of(input logic [7:0] sel, input int idx);
        return {1'b0, sel[2*idx +: 2]};
    endfunction

    wire uv = supply_undervoltage_lockout;
    wire ot = die_over_temp;
    wire en_in = enable_sync_input;
    wire slot_tick = slot_cnt == CNT_W'(SLOT_CYCLES - 1);
    wire burn_busy = burn_cnt != '0;
    wire unlocked = unlock == UNLOCK_CODE;
    wire wr_ok = reg_req.wr && !burn_busy && !uv;
    wire seq_off = addr_ctl[SEQ_OFF_BIT];
    wire burn_req = wr_ok && reg_req.addr == SYS_CTL_OFS && unlocked
        && reg_req.wdata[BURN_BIT];

    // Slot index after this edge; rails key off it so each slot lasts exactly one slot time
    wire [2:0] next_on_slot = (state != ST_ON_SEQ) ? 3'h0 :
        (slot_tick && on_slot != ON_SLOT_LAST) ? on_slot + 3'h1 : on_slot;

    // Per-rail decode: enable bit, slot reached, slot still kept on
    wire [3:0] rail_bit;
    wire [3:0] on_go;
    wire [3:0] off_keep;
    wire [3:0] pending;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rail
            assign rail_bit[gi] = rail_ctl[RAIL1_EN_BIT - gi];
            assign on_go[gi] = rail_bit[gi] && slot_of(slot_sel, gi) <= next_on_slot;
            assign off_keep[gi] = seq_off && slot_of(slot_sel, gi) < off_slot;
            assign pending[gi] = rail_bit[gi] && slot_of(slot_sel, gi) >= on_slot;
        end
    endgenerate

    wire all_good = (rail_good & rail_bit) == rail_bit;
    wire on_done = pending == 4'h0 && all_good;

    // Next state; undervoltage beats everything, over-temperature next
    always_comb begin
        next_state = state;
        case (state)
            ST_NO_SUPPLY: begin
                if (!uv) next_state = ST_POWER_OFF;
            end
            ST_POWER_OFF: begin
                if (ot) next_state = ST_THERMAL_HOLD;
                else if (en_in) next_state = ST_ON_SEQ;
            end
            ST_ON_SEQ: begin
                if (ot) next_state = ST_THERMAL_HOLD;
                else if (!en_in) next_state = ST_POWER_OFF;
                else if (on_done) next_state = ST_POWER_ON;
            end
            ST_POWER_ON: begin
                if (ot) next_state = ST_THERMAL_HOLD;
                else if (!en_in) next_state = ST_OFF_SEQ;
            end
            ST_OFF_SEQ: begin
                // Enable is blanked so the outputs finish discharging
                if (ot) next_state = ST_THERMAL_HOLD;
                else if (off_slot == 3'h0) next_state = ST_POWER_OFF;
            end
            ST_THERMAL_HOLD: begin
                if (!ot) next_state = en_in ? ST_ON_SEQ : ST_POWER_OFF;
            end
            default: next_state = ST_NO_SUPPLY;
        endcase
        if (uv) next_state = ST_NO_SUPPLY;
    end

    // Rail drive follows the state being entered
    wire [3:0] next_rail =
        (next_state == ST_ON_SEQ) ? on_go :
        (next_state == ST_POWER_ON) ? rail_enable :
        (next_state == ST_OFF_SEQ && state == ST_OFF_SEQ) ? (rail_enable & off_keep) :
        (next_state == ST_OFF_SEQ) ? rail_enable : 4'h0;

    // State, rails, power good
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_NO_SUPPLY;
            rail_enable <= 4'h0;
            power_good_output <= 1'b0;
            thermal_shutdown_flag <= 1'b0;
        end else begin
            state <= next_state;
            rail_enable <= next_rail;
            power_good_output <= next_state == ST_POWER_ON;
            thermal_shutdown_flag <= next_state == ST_THERMAL_HOLD;
        end
    end

    // Slot timer restarts on every state change
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slot_cnt <= '0;
        end else if (state != next_state || slot_tick) begin
            slot_cnt <= '0;
        end else begin
            slot_cnt <= slot_cnt + CNT_W'(1);
        end
    end

    // Slot indexes: up while powering on, down while powering off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            on_slot <= 3'h0;
            off_slot <= OFF_SLOT_START;
        end else begin
            if (state != ST_ON_SEQ) on_slot <= 3'h0;
            else if (slot_tick && on_slot != ON_SLOT_LAST) on_slot <= on_slot + 3'h1;
            if (state != ST_OFF_SEQ) off_slot <= OFF_SLOT_START;
            else if (slot_tick && off_slot != 3'h0) off_slot <= off_slot - 3'h1;
        end
    end

    // Register writes; writes are locked out while a burn runs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rail_ctl <= RAIL_CTL_RST;
            addr_ctl <= ADDR_CTL_RST;
            sys_ctl <= SYS_CTL_RST;
            slot_sel <= SLOT_SEL_RST;
            unlock <= UNLOCK_RST;
        end else if (uv) begin
            rail_ctl <= RAIL_CTL_RST;
            addr_ctl <= ADDR_CTL_RST;
            sys_ctl <= SYS_CTL_RST;
            slot_sel <= SLOT_SEL_RST;
            unlock <= UNLOCK_RST;
        end else if (burn_cnt == CNT_W'(1)) begin
            sys_ctl[BURN_BIT] <= 1'b0;
        end else if (wr_ok) begin
            if (reg_req.addr == RAIL_CTL_OFS) begin
                rail_ctl <= reg_req.wdata;
            end else if (reg_req.addr == ADDR_CTL_OFS) begin
                addr_ctl <= reg_req.wdata;
            end else if (reg_req.addr == SYS_CTL_OFS) begin
                sys_ctl <= {reg_req.wdata[7:6], burn_req, reg_req.wdata[4:0]};
            end else if (reg_req.addr == UNLOCK_OFS) begin
                unlock <= reg_req.wdata;
            end else if (reg_req.addr == SLOT_SEL_OFS) begin
                slot_sel <= reg_req.wdata;
            end
        end
    end

    // Burn timer, page index and checksum flag; these survive undervoltage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            burn_cnt <= '0;
            active_page_index <= 3'h0;
            crc_flag <= 1'b1;
        end else if (burn_req) begin
            burn_cnt <= CNT_W'(BURN_CYCLES);
        end else if (burn_busy) begin
            burn_cnt <= burn_cnt - CNT_W'(1);
            if (burn_cnt == CNT_W'(1)) begin
                active_page_index <= active_page_index + 3'h1;
                crc_flag <= burn_crc_error;
            end
        end
    end

    // Read selection and slave address
    wire [7:0] status_word = {rail_good[0], rail_good[1], rail_good[2], rail_good[3],
        die_hot_warning, thermal_shutdown_flag, 2'b00};
    wire [7:0] page_word = {VENDOR_ID, crc_flag, active_page_index};
    wire [7:0] rd_mux =
        (reg_req.addr == RAIL_CTL_OFS) ? rail_ctl :
        (reg_req.addr == ADDR_CTL_OFS) ? addr_ctl :
        (reg_req.addr == SYS_CTL_OFS) ? sys_ctl :
        (reg_req.addr == STATUS_OFS) ? status_word :
        (reg_req.addr == PAGE_INFO_OFS) ? page_word :
        (reg_req.addr == SLOT_SEL_OFS) ? slot_sel : 8'h00;
    wire pin_addr = sys_ctl[GPIO_MODE_LSB +: 2] == GPIO_ADDR_MODE;
    wire [4:0] reg_addr = addr_ctl[ADDR_LSB +: 5];
    wire [6:0] next_slave = pin_addr ? {ADDR_FIXED, reg_addr[4:2], add_band}
        : {ADDR_FIXED, reg_addr};

    // Read answers one cycle after the request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            wr_refused <= 1'b0;
            slave_addr <= {ADDR_FIXED, ADDR_CTL_RST[4:0]};
        end else begin
            rd_valid <= reg_req.rd && !uv;
            if (reg_req.rd && !uv) rd_data <= rd_mux;
            wr_refused <= reg_req.wr && (burn_busy || uv);
            slave_addr <= next_slave;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_enter_off;
        state == ST_POWER_ON && next_state == ST_OFF_SEQ;
    endsequence

    pg_only_on_a: assert property (power_good_output |-> state == ST_POWER_ON)
        else $error("power good high outside power-on");
    pg_first_a: assert property (s_enter_off |=> !power_good_output
        && rail_enable == $past(rail_enable))
        else $error("rail dropped before power good");
    all_off_a: assert property (state == ST_OFF_SEQ && $past(state) == ST_OFF_SEQ
        && !seq_off |-> rail_enable == 4'h0)
        else $error("rails not off together");
    en_blank_a: assert property (state == ST_OFF_SEQ && off_slot != 3'h0 && !ot && !uv
        |=> state == ST_OFF_SEQ)
        else $error("power-off sequence left early");
    start_seq_a: assert property (state == ST_POWER_OFF && en_in && !ot && !uv
        |=> state == ST_ON_SEQ && rail_enable == (rail_enable & rail_bit))
        else $error("enable did not start sequence");
    abort_seq_a: assert property (state == ST_ON_SEQ && !en_in && !ot && !uv
        |=> state == ST_POWER_OFF && rail_enable == 4'h0)
        else $error("sequence not aborted");
    thermal_back_a: assert property (state == ST_THERMAL_HOLD && !ot && en_in && !uv
        |=> state == ST_ON_SEQ && !thermal_shutdown_flag)
        else $error("no restart after cooling");
    pin_addr_a: assert property (pin_addr && $stable(pin_addr)
        |=> slave_addr[1:0] == $past(add_band))
        else $error("address pin not applied");
    burn_end_a: assert property (burn_cnt == CNT_W'(1) && !uv
        |=> !sys_ctl[BURN_BIT] && active_page_index == $past(active_page_index) + 3'h1)
        else $error("burn end not handled");
    uv_dflt_a: assert property (uv |=> addr_ctl == ADDR_CTL_RST && state == ST_NO_SUPPLY)
        else $error("undervoltage did not restore");
    status_rd_a: assert property (reg_req.rd && reg_req.addr == STATUS_OFS && !uv
        |=> rd_data[7:4] == {$past(rail_good[0]), $past(rail_good[1]),
        $past(rail_good[2]), $past(rail_good[3])})
        else $error("status read wrong");
endmodule

// [testbench/qps_host_model.sv]
`timescale 1ns/1ps
// Host behind the serial slave, seen as byte strobes on the register port
module qps_host_model (
    input wire logic clk,
    output qps_pkg::qps_req_t reg_req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic wr_refused
);
    import qps_pkg::*;

    initial reg_req = '0;

    // One write strobe; the caller sends the unlock code before a burn request
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic refused);
        @(negedge clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_req.wr = 1'b0;
        refused = wr_refused;
    endtask

    // Bounded wait for the answer; no answer leaves unknown data, so it cannot pass
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        d = 8'hXX;
        @(negedge clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        reg_req.rd = 1'b0;
        for (int n = 0; n < 3; n++) begin
            if (rd_valid === 1'b1) begin
                d = rd_data;
                break;
            end
            @(negedge clk);
        end
    endtask
endmodule

// [testbench/quad_rail_power_sequencer_test.sv]
`timescale 1ns/1ps
module quad_rail_power_sequencer_test;
    import qps_pkg::*;
    localparam int SLOT = 8;
    localparam int BURN = 10;
    logic clk, rst_b, supply_undervoltage_lockout, enable_sync_input, die_over_temp;
    logic die_hot_warning, burn_crc_error, good_force, refused;
    logic power_good_output, thermal_shutdown_flag, rd_valid, wr_refused;
    logic [3:0] rail_good, good_val, rail_enable;
    logic [1:0] add_band;
    logic [7:0] rd_data;
    logic [6:0] slave_addr;
    qps_req_t reg_req;
    int err_total, tests_run, ev[4];

    // Rails report good as soon as they are commanded, unless a test forces levels
    assign rail_good = good_force ? good_val : rail_enable;

    qps_sequencer #(.SLOT_CYCLES(SLOT), .BURN_CYCLES(BURN)) i_dut (
        .clk(clk), .rst_b(rst_b), .supply_undervoltage_lockout(supply_undervoltage_lockout),
        .enable_sync_input(enable_sync_input), .die_over_temp(die_over_temp),
        .die_hot_warning(die_hot_warning), .rail_good(rail_good), .add_band(add_band),
        .burn_crc_error(burn_crc_error), .reg_req(reg_req), .rail_enable(rail_enable),
        .power_good_output(power_good_output), .thermal_shutdown_flag(thermal_shutdown_flag),
        .rd_data(rd_data), .rd_valid(rd_valid), .wr_refused(wr_refused),
        .slave_addr(slave_addr)
    );

    qps_host_model i_host (
        .clk(clk), .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_refused(wr_refused)
    );

    always #20 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_host.wr(a, d, refused);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        check(d, exp);
    endtask

    // Address output is registered, so allow it a few cycles to follow
    task automatic achk(input logic [6:0] exp);
        for (int n = 0; n < 3 && slave_addr !== exp; n++) @(negedge clk);
        check({1'b0, slave_addr}, {1'b0, exp});
    endtask

    // Record the cycle at which each rail first reaches lvl; stop at the end state
    task automatic watch(input logic lvl, input int lim);
        for (int i = 0; i < 4; i++) ev[i] = -1;
        for (int n = 0; n < lim; n++) begin
            @(negedge clk);
            for (int i = 0; i < 4; i++) if (ev[i] < 0 && rail_enable[i] === lvl) ev[i] = n;
            if (lvl ? power_good_output === 1'b1 : rail_enable === 4'h0) break;
        end
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report;
    end

    initial begin
        {clk, rst_b, supply_undervoltage_lockout, enable_sync_input, die_over_temp} = '0;
        {die_hot_warning, burn_crc_error, good_force, good_val, add_band} = '0;
        err_total = 0;
        tests_run = 0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        achk(7'h68);
        // Status bits follow live inputs
        good_force = 1'b1;
        good_val = 4'b0101;
        die_hot_warning = 1'b1;
        rchk(STATUS_OFS, 8'hA8);
        good_val = 4'b1010;
        die_hot_warning = 1'b0;
        rchk(STATUS_OFS, 8'h50);
        good_force = 1'b0;
        rchk(PAGE_INFO_OFS, {VENDOR_ID, 4'h8});
        rchk(UNLOCK_OFS, 8'h00);
        rchk(8'h3F, 8'h00);
        // Address register, then pin bands overriding A2:A1
        w(ADDR_CTL_OFS, 8'h2B);
        achk(7'h6B);
        w(SYS_CTL_OFS, 8'h00);
        for (int b = 0; b < 4; b++) begin
            add_band = 2'(b);
            achk(7'h68 | 7'(b));
        end
        w(SYS_CTL_OFS, SYS_CTL_RST);
        achk(7'h6B);
        // Burn refused without the code, then taken with it
        w(SYS_CTL_OFS, 8'h60);
        rchk(SYS_CTL_OFS, 8'h40);
        w(UNLOCK_OFS, UNLOCK_CODE);
        w(SYS_CTL_OFS, 8'h60);
        i_host.wr(ADDR_CTL_OFS, 8'h28, refused);
        check({7'h0, refused}, 8'h01);
        repeat (BURN + 5) @(negedge clk);
        rchk(SYS_CTL_OFS, 8'h40);
        rchk(PAGE_INFO_OFS, {VENDOR_ID, 4'h1});
        achk(7'h6B);
        // Power-on with rail 3 disabled; slots 0,1,2,3 for rails 1..4
        w(RAIL_CTL_OFS, 8'hD0);
        check({power_good_output, 3'h0, rail_enable}, 8'h00);
        enable_sync_input = 1'b1;
        watch(1'b1, 80);
        check(8'(ev[1] - ev[0]), 8'(SLOT));
        check(8'(ev[3] - ev[0]), 8'(3 * SLOT));
        check({power_good_output, 3'h0, rail_enable}, 8'h8B);
        // Sequenced power-off; enable raised and left high meanwhile is ignored
        enable_sync_input = 1'b0;
        @(negedge clk);
        check({power_good_output, 3'h0, rail_enable}, 8'h0B);
        enable_sync_input = 1'b1;
        watch(1'b0, 80);
        check(8'(ev[1] - ev[3]), 8'(2 * SLOT));
        check(8'(ev[0] - ev[1]), 8'(SLOT));
        // Abort a power-on sequence after the first slot starts
        repeat (3) @(negedge clk);
        check({4'h0, rail_enable}, 8'h01);
        enable_sync_input = 1'b0;
        repeat (3) @(negedge clk);
        check({power_good_output, 3'h0, rail_enable}, 8'h00);
        // Simultaneous power-off
        w(ADDR_CTL_OFS, 8'h08);
        enable_sync_input = 1'b1;
        watch(1'b1, 80);
        enable_sync_input = 1'b0;
        watch(1'b0, 80);
        check(8'(ev[0] - ev[3]), 8'h00);
        check(8'(ev[1] - ev[3]), 8'h00);
        // Thermal shutdown keeps registers and recovers on its own
        enable_sync_input = 1'b1;
        watch(1'b1, 80);
        die_over_temp = 1'b1;
        repeat (2) @(negedge clk);
        check({3'h0, thermal_shutdown_flag, rail_enable}, 8'h10);
        rchk(STATUS_OFS, 8'h04);
        rchk(ADDR_CTL_OFS, 8'h08);
        die_over_temp = 1'b0;
        watch(1'b1, 80);
        check({power_good_output, 3'h0, rail_enable}, 8'h8B);
        // Undervoltage restores defaults but keeps the page index
        supply_undervoltage_lockout = 1'b1;
        repeat (2) @(negedge clk);
        check({power_good_output, 3'h0, rail_enable}, 8'h00);
        supply_undervoltage_lockout = 1'b0;
        rchk(ADDR_CTL_OFS, ADDR_CTL_RST);
        rchk(PAGE_INFO_OFS, {VENDOR_ID, 4'h1});
        achk(7'h68);
        final_report;
    end
endmodule
